// File: src/swm_switch_ctrl.sv
// Purpose: control logic of a two-bank to four-port switch
// Assumes: serial pins are asynchronous and oversampled by ref_clk
// Notes: serial clock must be well below a quarter of ref_clk
`timescale 1ns/1ps

// Function
// - bank b disabled opens every b switch
// - bank b select picks port 0..3
// - routing register decodes like direct pins
// - same port: bank a wins, b floats
// - serial target accepts repeated start
// - address is 0111 plus three select pins
// - direction bit one reads, zero writes
// - aux output pairs: float bit, data bit
// - routing layout, bits 1:0 hardwired zero
// - mode pin picks pins or serial control
// - bank a enable and select route a
// - reset loads routing 00, aux AA
// - serial mode: shared pins out, b pins floated
module swm_switch_ctrl
    import swm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // mode and address straps
    input wire logic mode_pin,
    input wire logic addr_select_pin_2,
    input wire logic addr_select_pin_1,
    input wire logic addr_select_pin_0,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // shared direct-control pins, inputs in direct mode
    input wire logic bank_a_select_lo_pin,
    input wire logic bank_a_select_hi_pin,
    input wire logic bank_a_enable_pin,
    input wire logic bank_b_select_lo_pin,
    // direct-control only pins
    input wire logic bank_b_select_hi_pin,
    input wire logic bank_b_enable_pin,
    // aux outputs on the shared pins
    output logic aux_out_0,
    output logic aux_out_0_oe,
    output logic aux_out_1,
    output logic aux_out_1_oe,
    output logic aux_out_2,
    output logic aux_out_2_oe,
    output logic aux_out_3,
    output logic aux_out_3_oe,
    // switch closures per common port
    output logic [SWM_NPORT-1:0] bank_a_to_port,
    output logic [SWM_NPORT-1:0] bank_b_to_port
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    logic scl_prev_q;
    logic sda_prev_q;

    assign pins_raw = {mode_pin, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0,
                       bank_b_enable_pin, bank_b_select_hi_pin, bank_b_select_lo_pin,
                       bank_a_enable_pin, bank_a_select_hi_pin, bank_a_select_lo_pin,
                       scl_in, sda_in};

    // idle bus lines are high, so they reset high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 12'h003;
            sync_q <= 12'h003;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
            scl_prev_q <= sync_q[1];
            sda_prev_q <= sync_q[0];
        end
    end

    logic serial_mode;
    logic [2:0] addr_pins;
    logic scl_s;
    logic sda_s;
    swm_bank_s pin_a;
    swm_bank_s pin_b;

    assign serial_mode = (sync_q[11] == SWM_MODE_SERIAL);
    assign addr_pins = sync_q[10:8];
    assign pin_b = swm_bank_s'(sync_q[7:5]);
    assign pin_a = swm_bank_s'(sync_q[4:2]);
    assign scl_s = sync_q[1];
    assign sda_s = sync_q[0];

    // ------------------------------------------------------------
    // bus events
    // ------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    // a start seen in any state restarts the frame, so a repeated start works
    assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_ev = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // ------------------------------------------------------------
    // target state machine
    // ------------------------------------------------------------
    swm_i2c_e st_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] idx_q;
    logic full_q;
    logic rd_q;
    logic acked_q;
    logic oe_q;
    logic [7:0] routing_q;
    logic [7:0] aux_q;

    logic addr_hit;
    logic [7:0] rd_data;
    logic wr_en;

    assign addr_hit = (shift_q[7:1] == {SWM_ADDR_FIXED, addr_pins});
    assign rd_data = (idx_q == SWM_IDX_ROUTING) ? routing_q :
                     (idx_q == SWM_IDX_AUX) ? aux_q : SWM_READ_UNMAPPED;
    assign wr_en = (st_q == SWM_WDATA) && scl_fall && full_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SWM_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            idx_q <= 8'h00;
            full_q <= 1'b0;
            rd_q <= 1'b0;
            acked_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (start_ev) begin
            st_q <= SWM_ADDR;
            bit_q <= 3'h0;
            full_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (stop_ev) begin
            st_q <= SWM_IDLE;
            oe_q <= 1'b0;
        end else begin
            unique case (st_q)
                SWM_IDLE: begin
                    oe_q <= 1'b0;
                end
                SWM_ADDR, SWM_INDEX, SWM_WDATA: begin
                    if (scl_rise && !full_q) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_q <= bit_q + 3'h1;
                        full_q <= (bit_q == SWM_BIT_LAST);
                    end else if (scl_fall && full_q) begin
                        full_q <= 1'b0;
                        oe_q <= 1'b1;
                        if (st_q == SWM_ADDR) begin
                            if (addr_hit) begin
                                rd_q <= (shift_q[0] == SWM_DIR_READ);
                                st_q <= SWM_ACK_ADDR;
                            end else begin
                                oe_q <= 1'b0;
                                st_q <= SWM_IDLE;
                            end
                        end else begin
                            if (st_q == SWM_INDEX) begin
                                idx_q <= shift_q;
                            end else begin
                                idx_q <= idx_q + 8'h01;
                            end
                            st_q <= SWM_ACK_W;
                        end
                    end
                end
                SWM_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rd_q) begin
                            shift_q <= rd_data;
                            oe_q <= !rd_data[7];
                            bit_q <= 3'h0;
                            st_q <= SWM_TX;
                        end else begin
                            oe_q <= 1'b0;
                            st_q <= SWM_INDEX;
                        end
                    end
                end
                SWM_ACK_W: begin
                    if (scl_fall) begin
                        oe_q <= 1'b0;
                        st_q <= SWM_WDATA;
                    end
                end
                SWM_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == SWM_BIT_LAST) begin
                            oe_q <= 1'b0;
                            idx_q <= idx_q + 8'h01;
                            st_q <= SWM_RACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            oe_q <= !shift_q[6];
                        end
                    end
                end
                SWM_RACK: begin
                    if (scl_rise) begin
                        acked_q <= !sda_s;
                    end else if (scl_fall) begin
                        // a refused byte ends the read, the bus is released
                        if (acked_q) begin
                            shift_q <= rd_data;
                            oe_q <= !rd_data[7];
                            bit_q <= 3'h0;
                            st_q <= SWM_TX;
                        end else begin
                            st_q <= SWM_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            routing_q <= SWM_ROUTING_RESET;
            aux_q <= SWM_AUX_RESET;
        end else if (wr_en && (idx_q == SWM_IDX_ROUTING)) begin
            // low bits stay hardwired, writes to them are dropped
            routing_q <= (shift_q & SWM_ROUTING_WMASK) | SWM_ROUTING_HARD;
        end else if (wr_en && (idx_q == SWM_IDX_AUX)) begin
            aux_q <= shift_q;
        end
    end

    // ------------------------------------------------------------
    // route selection and decode
    // ------------------------------------------------------------
    swm_bank_s reg_a;
    swm_bank_s reg_b;
    swm_bank_s use_a;
    swm_bank_s use_b;
    logic [SWM_NPORT-1:0] a_close;
    logic [SWM_NPORT-1:0] b_close;
    logic [SWM_NAUX-1:0] aux_val;
    logic [SWM_NAUX-1:0] aux_oe;

    assign reg_b = {routing_q[SWM_B_EN_BIT], routing_q[SWM_B_SEL_HI:SWM_B_SEL_LO]};
    assign reg_a = {routing_q[SWM_A_EN_BIT], routing_q[SWM_A_SEL_HI:SWM_A_SEL_LO]};
    // register fields feed the same decoder as the pins
    assign use_a = serial_mode ? reg_a : pin_a;
    assign use_b = serial_mode ? reg_b : pin_b;

    swm_route_decode u_decode (
        .bank_a(use_a),
        .bank_b(use_b),
        .a_close(a_close),
        .b_close(b_close)
    );

    swm_aux_drive u_aux (
        .serial_mode(serial_mode),
        .aux_reg(aux_q),
        .aux_val(aux_val),
        .aux_oe(aux_oe)
    );

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // one extra cycle of latency keeps every output glitch free
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_a_to_port <= '0;
            bank_b_to_port <= '0;
            {aux_out_3, aux_out_2, aux_out_1, aux_out_0} <= 4'h0;
            {aux_out_3_oe, aux_out_2_oe, aux_out_1_oe, aux_out_0_oe} <= 4'h0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            bank_a_to_port <= a_close;
            bank_b_to_port <= b_close;
            {aux_out_3, aux_out_2, aux_out_1, aux_out_0} <= aux_val;
            {aux_out_3_oe, aux_out_2_oe, aux_out_1_oe, aux_out_0_oe} <= aux_oe;
            sda_out <= 1'b0;
            sda_oe <= oe_q;
        end
    end

endmodule // swm_switch_ctrl

// File: include/swm_pkg.sv
// Purpose: shared constants and types for the switch matrix control block
// Assumes: 8-bit registers, 7-bit serial target address
// Notes: register indices are the byte indices sent after the address byte
package swm_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] SWM_IDX_ROUTING = 8'h00;
    localparam logic [7:0] SWM_IDX_AUX = 8'h01;
    localparam logic [7:0] SWM_ROUTING_RESET = 8'h00;
    localparam logic [7:0] SWM_AUX_RESET = 8'hAA;
    localparam logic [7:0] SWM_ROUTING_WMASK = 8'hFC;
    localparam logic [7:0] SWM_ROUTING_HARD = 8'h00;
    localparam logic [7:0] SWM_READ_UNMAPPED = 8'h00;

    // routing field positions
    localparam int SWM_B_EN_BIT = 7;
    localparam int SWM_B_SEL_HI = 6;
    localparam int SWM_B_SEL_LO = 5;
    localparam int SWM_A_EN_BIT = 4;
    localparam int SWM_A_SEL_HI = 3;
    localparam int SWM_A_SEL_LO = 2;

    // ------------------------------------------------------------
    // serial target
    // ------------------------------------------------------------
    localparam logic [3:0] SWM_ADDR_FIXED = 4'h7;
    localparam logic SWM_DIR_READ = 1'b1;
    localparam logic [2:0] SWM_BIT_LAST = 3'h7;
    localparam logic SWM_MODE_SERIAL = 1'b1;
    localparam int SWM_NPORT = 4;
    localparam int SWM_NAUX = 4;

    typedef struct packed {
        logic en;
        logic [1:0] sel;
    } swm_bank_s;

    typedef enum logic [2:0] {
        SWM_IDLE,
        SWM_ADDR,
        SWM_ACK_ADDR,
        SWM_INDEX,
        SWM_WDATA,
        SWM_ACK_W,
        SWM_TX,
        SWM_RACK
    } swm_i2c_e;

endpackage

// File: src/swm_route_decode.sv
// Purpose: decode two bank routes into per-port closures
// Assumes: inputs already chosen from pins or register
// Notes: purely combinational, the top registers the result
`timescale 1ns/1ps
module swm_route_decode
    import swm_pkg::*;
(
    // bank requests
    input wire swm_bank_s bank_a,
    input wire swm_bank_s bank_b,
    // closures, one bit per common port
    output logic [SWM_NPORT-1:0] a_close,
    output logic [SWM_NPORT-1:0] b_close
);

    logic clash;

    // bank a wins a shared port, bank b floats
    assign clash = bank_a.en && (bank_a.sel == bank_b.sel);

    genvar p;
    generate
        for (p = 0; p < SWM_NPORT; p++) begin : g_port
            assign a_close[p] = bank_a.en && (bank_a.sel == 2'(p));
            assign b_close[p] = bank_b.en && (bank_b.sel == 2'(p)) && !clash;
        end
    endgenerate

endmodule // swm_route_decode

// File: src/swm_aux_drive.sv
// Purpose: map the aux output register onto four tri-state outputs
// Assumes: serial mode flag is synchronous to the caller
// Notes: combinational, the top registers the result
`timescale 1ns/1ps
module swm_aux_drive
    import swm_pkg::*;
(
    // control
    input wire logic serial_mode,
    input wire logic [7:0] aux_reg,
    // outputs
    output logic [SWM_NAUX-1:0] aux_val,
    output logic [SWM_NAUX-1:0] aux_oe
);

    genvar i;
    generate
        for (i = 0; i < SWM_NAUX; i++) begin : g_aux
            // upper bit of each pair floats the output
            assign aux_oe[i] = serial_mode && !aux_reg[2*i+1];
            assign aux_val[i] = aux_reg[2*i];
        end
    endgenerate

endmodule // swm_aux_drive

// File: verif/swm_switch_ctrl_assertions.sv
// Purpose: port assertions for the switch matrix control block
// Assumes: direct pins held steady while their result is judged
// Notes: seven quiet cycles cover pin sync plus output flop
`timescale 1ns/1ps
module swm_switch_ctrl_assertions
    import swm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control inputs
    input wire logic mode_pin,
    input wire logic bank_a_select_lo_pin,
    input wire logic bank_a_select_hi_pin,
    input wire logic bank_a_enable_pin,
    input wire logic bank_b_select_lo_pin,
    input wire logic bank_b_select_hi_pin,
    input wire logic bank_b_enable_pin,
    // watched outputs
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic aux_out_0_oe,
    input wire logic aux_out_1_oe,
    input wire logic aux_out_2_oe,
    input wire logic aux_out_3_oe,
    input wire logic [SWM_NPORT-1:0] bank_a_to_port,
    input wire logic [SWM_NPORT-1:0] bank_b_to_port
);
    // --------
    // expected closures
    // --------
    wire [5:0] pins = {bank_b_enable_pin, bank_b_select_hi_pin, bank_b_select_lo_pin,
        bank_a_enable_pin, bank_a_select_hi_pin, bank_a_select_lo_pin};
    wire [3:0] oes = {aux_out_3_oe, aux_out_2_oe, aux_out_1_oe, aux_out_0_oe};
    wire [3:0] exp_a = pins[2] ? 4'h1 << pins[1:0] : 4'h0;
    // b loses any port that a already holds
    wire [3:0] exp_b = (pins[5] ? 4'h1 << pins[4:3] : 4'h0) & ~exp_a;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence quiet_direct;
        (!mode_pin && $stable(pins))[*7];
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn |-> (bank_a_to_port | bank_b_to_port) == 4'h0 && oes == 4'h0 && !sda_oe)
        else $error("outputs active in reset");
    a_port_single: assert property ($onehot0(bank_a_to_port) && $onehot0(bank_b_to_port))
        else $error("bank closed onto two ports");
    a_clash_b_open: assert property ((bank_a_to_port & bank_b_to_port) == 4'h0)
        else $error("both banks on one port");
    a_b_off_open: assert property ((!mode_pin && !bank_b_enable_pin)[*7] |-> bank_b_to_port == 4'h0)
        else $error("disabled bank b closed");
    a_route_a: assert property (quiet_direct |-> bank_a_to_port == exp_a)
        else $error("bank a route wrong");
    a_route_b: assert property (quiet_direct |-> bank_b_to_port == exp_b)
        else $error("bank b route wrong");
    a_aux_off_direct: assert property ((!mode_pin)[*6] |-> oes == 4'h0)
        else $error("aux driven in direct mode");
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda driven high");

    c_clash: cover property (quiet_direct ##0 pins[5] && pins[2] && pins[4:3] == pins[1:0]);
    c_serial_ack: cover property ($rose(sda_oe));
    c_aux_drive: cover property (oes != 4'h0);
endmodule // swm_switch_ctrl_assertions

// File: verif/swm_i2c_master.sv
// Purpose: serial bus master facing the switch block
// Assumes: one master, sda pulled up when released
// Notes: hp is the phase length, raise it for a slow bus
`timescale 1ns/1ps
module swm_i2c_master (
    // clock
    input wire logic ref_clk,
    // bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    int hp = 10;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // scl only moves with sda steady, so no false start or stop
    task automatic ph(input logic c, input logic l);
        @(negedge ref_clk);
        scl = c;
        sda_low = l;
        repeat (hp) @(negedge ref_clk);
    endtask
    task automatic start();
        ph(scl, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        ph(1'b0, 1'b1);
    endtask
    task automatic stop();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    task automatic bit_io(input logic b, output logic r);
        ph(1'b0, !b);
        ph(1'b1, !b);
        r = sda_line;
        ph(1'b0, !b);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(last, nak);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic n0, n1, n2;
        start();
        xfer({a, 1'b0}, 1'b1, rx, n0);
        xfer(idx, 1'b1, rx, n1);
        xfer(d, 1'b1, rx, n2);
        stop();
        ok = !(n0 | n1 | n2);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic n0, n1, n2, n3;
        start();
        xfer({a, 1'b0}, 1'b1, rx, n0);
        xfer(idx, 1'b1, rx, n1);
        start();
        xfer({a, 1'b1}, 1'b1, rx, n2);
        xfer(8'hFF, 1'b1, d, n3);
        stop();
        ok = !(n0 | n1 | n2);
    endtask
endmodule // swm_i2c_master

// File: verif/testbench.sv
// Purpose: self-checking bench for the switch matrix control block
// Assumes: serial traffic comes from swm_i2c_master
// Notes: expectations come from a small integer model
`timescale 1ns/1ps
bind swm_switch_ctrl swm_switch_ctrl_assertions chk (.ref_clk, .resetn, .mode_pin, .bank_a_select_lo_pin,
    .bank_a_select_hi_pin, .bank_a_enable_pin, .bank_b_select_lo_pin, .bank_b_select_hi_pin,
    .bank_b_enable_pin, .sda_out, .sda_oe, .aux_out_0_oe, .aux_out_1_oe, .aux_out_2_oe, .aux_out_3_oe,
    .bank_a_to_port, .bank_b_to_port);
module testbench
    import swm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic resetn = 1'b1;
    logic mode = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [5:0] dpin = 6'h00;
    logic scl, m_low, sda_oe, sda_out, ok;
    logic [3:0] aux_val, aux_oe, a_port, b_port;
    logic [6:0] dev;
    logic [7:0] rd, d;
    int fails = 0;
    int tests_run = 0;
    int regs[2] = '{0, 'hAA};
    wire sda_line = !m_low && (!sda_oe || sda_out);
    // shared pads: the 10k pull-down wins when nobody drives
    wire [3:0] pad = (aux_oe & aux_val) | (~aux_oe & (mode ? 4'h0 : dpin[3:0]));

    always #10 ref_clk = ~ref_clk;

    swm_switch_ctrl uut (.ref_clk, .resetn, .mode_pin(mode), .addr_select_pin_2(strap[2]),
        .addr_select_pin_1(strap[1]), .addr_select_pin_0(strap[0]), .scl_in(scl), .sda_in(sda_line),
        .sda_out, .sda_oe, .bank_a_select_lo_pin(pad[0]), .bank_a_select_hi_pin(pad[1]),
        .bank_a_enable_pin(pad[2]), .bank_b_select_lo_pin(pad[3]), .bank_b_select_hi_pin(dpin[4]),
        .bank_b_enable_pin(dpin[5]), .aux_out_0(aux_val[0]), .aux_out_0_oe(aux_oe[0]),
        .aux_out_1(aux_val[1]), .aux_out_1_oe(aux_oe[1]), .aux_out_2(aux_val[2]), .aux_out_2_oe(aux_oe[2]),
        .aux_out_3(aux_val[3]), .aux_out_3_oe(aux_oe[3]), .bank_a_to_port(a_port), .bank_b_to_port(b_port));
    swm_i2c_master m (.ref_clk, .sda_line, .scl, .sda_low(m_low));

    // v holds {b en, b sel, a en, a sel}; result is {b, a} closures
    function automatic logic [7:0] route_exp(int v);
        int a = (v & 4) ? 1 << (v & 3) : 0;
        int b = (v & 32) ? 1 << (v >> 3 & 3) : 0;
        if ((a & b) != 0) begin
            b = 0;
        end
        return 8'(b << 4 | a);
    endfunction
    // result is {drive enables, driven values}
    function automatic logic [7:0] aux_exp(int x);
        int r = 0;
        for (int n = 0; n < 4; n++) begin
            if ((x >> (2 * n + 1) & 1) == 0) begin
                r = r | 1 << (4 + n) | (x >> 2 * n & 1) << n;
            end
        end
        return 8'(r);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // eight quiet cycles so the seven-cycle pin assertions also see each vector
    task automatic settle();
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] x);
        m.wr(dev, idx, x, ok);
        check("write ack", 8'(ok), 8'h01);
        if (idx < 2) begin
            regs[idx] = idx == 0 ? x & 'hFC : x;
        end
    endtask
    task automatic rreg(input logic [7:0] idx);
        m.rd(dev, idx, rd, ok);
        check("read ack", 8'(ok), 8'h01);
        check("read data", rd, idx < 2 ? 8'(regs[idx]) : 8'h00);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hE451));
        strap = 3'($urandom);
        dev = {SWM_ADDR_FIXED, strap};
        #2 resetn = 1'b0;
        repeat (5) @(negedge ref_clk);
        check("reset", {b_port | a_port, aux_oe}, 8'h00);
        resetn = 1'b1;
        settle();
        for (int v = 0; v < 64; v++) begin
            dpin = 6'(v);
            settle();
            check("direct", {b_port, a_port}, route_exp(v));
        end
        check("direct oe", {4'h0, aux_oe}, 8'h00);
        mode = 1'b1;
        settle();
        rreg(0);
        rreg(1);
        check("aux reset", {aux_oe, aux_oe & aux_val}, 8'h00);
        for (int k = 0; k < 10; k++) begin
            dpin = 6'($urandom);
            wreg(0, k == 0 ? 8'hB7 : 8'($urandom));
            settle();
            check("routing", {b_port, a_port}, route_exp(regs[0] >> 2));
            rreg(0);
        end
        for (int k = 0; k < 6; k++) begin
            d = k < 2 ? (k == 0 ? 8'h00 : 8'h55) : 8'($urandom);
            wreg(1, d);
            settle();
            check("aux", {aux_oe, aux_oe & aux_val}, aux_exp(d));
        end
        dev[6] = 1'b1;
        m.wr(dev, 8'h00, 8'h00, ok);
        check("foreign addr", 8'(ok), 8'h00);
        dev[6] = 1'b0;
        m.wr(dev, 8'h02, 8'h5A, ok);
        rreg(2);
        m.hp = 40;
        rreg(0);
        m.hp = 10;
        mode = 1'b0;
        dpin = 6'h2D;
        settle();
        check("clash", {b_port, a_port}, route_exp(45));
        check("direct oe", {4'h0, aux_oe}, 8'h00);
        resetn = 1'b0;
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        regs = '{0, 'hAA};
        settle();
        rreg(0);
        rreg(1);
        stop_test();
    end
endmodule // testbench
